// ==== inc/lro_pkg.sv ====
// Package for the relay output override block: register map, reset values, carriers.
// Assumes a word-addressed register port relative to the block base address.
package lro_pkg;
	localparam int LRO_ADDR_W = 16;
	localparam logic [LRO_ADDR_W-1:0] LRO_OFF_OUTPUT = 16'h0000;
	localparam logic [LRO_ADDR_W-1:0] LRO_OFF_ENABLE = 16'h0001;
	localparam logic [LRO_ADDR_W-1:0] LRO_OFF_VALUE = 16'h0002;
	localparam logic LRO_RST_ENABLE = 1'h0;
	localparam logic LRO_RST_VALUE = 1'h0;
	localparam logic LRO_RST_OUTPUT = 1'h0;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [LRO_ADDR_W-1:0] addr;
		logic wdata;
	} lro_req_s;

	typedef struct packed {
		logic valid;
		logic hit;
		logic rdata;
	} lro_rsp_s;
endpackage

// ==== hw/lro_override_regs.sv ====
// Override register pair: enable flag and forced value, written and read remotely.
// Assumes one request per clock on a synchronous register port.
`timescale 1ns/1ps
module lro_override_regs (
	input wire logic clock,
	input wire logic rst_n,
	input wire lro_pkg::lro_req_s req,
	input wire logic relay_point_output,
	output logic override_enable_flag,
	output logic override_forced_value,
	output lro_pkg::lro_rsp_s rsp
);
	import lro_pkg::*;

	logic enable_ff, nxt_enable;
	logic value_ff, nxt_value;
	lro_rsp_s rsp_ff, nxt_rsp;

	function automatic logic is_mapped(input logic [LRO_ADDR_W-1:0] a);
		is_mapped = (a == LRO_OFF_OUTPUT) || (a == LRO_OFF_ENABLE) || (a == LRO_OFF_VALUE);
	endfunction

	always_comb begin
		nxt_enable = enable_ff;
		nxt_value = value_ff;
		if (req.wr && req.addr == LRO_OFF_ENABLE) begin
			nxt_enable = req.wdata;
		end
		if (req.wr && req.addr == LRO_OFF_VALUE) begin
			nxt_value = req.wdata;
		end
		nxt_rsp.valid = req.rd || req.wr;
		nxt_rsp.hit = is_mapped(req.addr) && (req.rd || req.wr);
		case (req.addr)
			LRO_OFF_OUTPUT: nxt_rsp.rdata = relay_point_output;
			LRO_OFF_ENABLE: nxt_rsp.rdata = enable_ff;
			LRO_OFF_VALUE: nxt_rsp.rdata = value_ff;
			default: nxt_rsp.rdata = 1'h0;
		endcase
		if (!req.rd) begin
			nxt_rsp.rdata = 1'h0;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			enable_ff <= LRO_RST_ENABLE;
			value_ff <= LRO_RST_VALUE;
			rsp_ff <= '0;
		end else begin
			enable_ff <= nxt_enable;
			value_ff <= nxt_value;
			rsp_ff <= nxt_rsp;
		end
	end

	assign override_enable_flag = enable_ff;
	assign override_forced_value = value_ff;
	assign rsp = rsp_ff;

	a_enable_write: assert property (@(posedge clock) disable iff (!rst_n)
		req.wr && req.addr == LRO_OFF_ENABLE |=> enable_ff == $past(req.wdata))
		else $error("enable flag did not take written value");
	a_value_write: assert property (@(posedge clock) disable iff (!rst_n)
		req.wr && req.addr == LRO_OFF_VALUE |=> value_ff == $past(req.wdata))
		else $error("forced value did not take written value");
	a_unmapped_read: assert property (@(posedge clock) disable iff (!rst_n)
		req.rd && !is_mapped(req.addr) |=> rsp_ff.valid && !rsp_ff.hit && !rsp_ff.rdata)
		else $error("unmapped read not answered as miss");
	c_enable_set: cover property (@(posedge clock) disable iff (!rst_n) req.wr && req.addr == LRO_OFF_ENABLE && req.wdata);
endmodule

// ==== hw/lro_override_relay_block.sv ====
// Top of the relay output override: passes source input or forced value to the relay point.
// Assumes source_input is synchronous to clock; one evaluation per clock edge.
// Summary of operation
// - While the override flag is set, the relay output takes the forced value.
// - While the override flag is clear, the relay output follows the source input.
// - The override flag reads 1 when the override is active and 0 when passive.
// - The override flag is read and written remotely at base plus one and steers the override.
// - The forced value is read and written remotely at base plus two and is applied while active.
`timescale 1ns/1ps
module lro_override_relay_block (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic source_input,
	input wire lro_pkg::lro_req_s reg_req,
	output lro_pkg::lro_rsp_s reg_rsp,
	output logic relay_point_output,
	output logic lock_active
);
	import lro_pkg::*;

	logic flag;
	logic forced;
	logic out_ff, nxt_out;
	logic lock_ff, nxt_lock;

	lro_override_regs u_regs (
		.clock(clock),
		.rst_n(rst_n),
		.req(reg_req),
		.relay_point_output(out_ff),
		.override_enable_flag(flag),
		.override_forced_value(forced),
		.rsp(reg_rsp)
	);

	// Evaluated every clock from the registered flag and value
	always_comb begin
		nxt_lock = flag;
		if (flag) begin
			nxt_out = forced;
		end else begin
			nxt_out = source_input;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			out_ff <= LRO_RST_OUTPUT;
			lock_ff <= LRO_RST_ENABLE;
		end else begin
			out_ff <= nxt_out;
			lock_ff <= nxt_lock;
		end
	end

	assign relay_point_output = out_ff;
	assign lock_active = lock_ff;

	// Request decode shared by the port checks
	function automatic logic is_access_to(input lro_req_s q, input logic [LRO_ADDR_W-1:0] off);
		is_access_to = (q.wr || q.rd) && (q.addr == off);
	endfunction

	function automatic logic is_known_offset(input logic [LRO_ADDR_W-1:0] a);
		is_known_offset = (a == LRO_OFF_OUTPUT) || (a == LRO_OFF_ENABLE) || (a == LRO_OFF_VALUE);
	endfunction

	logic any_access;
	logic flag_write;
	logic value_write;
	logic known_access;
	logic unknown_access;

	assign any_access = reg_req.wr || reg_req.rd;
	assign flag_write = reg_req.wr && is_access_to(reg_req, LRO_OFF_ENABLE);
	assign value_write = reg_req.wr && is_access_to(reg_req, LRO_OFF_VALUE);
	assign known_access = any_access && is_known_offset(reg_req.addr);
	assign unknown_access = any_access && !is_known_offset(reg_req.addr);

	// Register port answers
	property p_answer_follows;
		@(posedge clock) disable iff (!rst_n)
		any_access |=> reg_rsp.valid;
	endproperty
	a_answer_follows: assert property (p_answer_follows)
		else $error("register request left unanswered");

	property p_answer_once;
		@(posedge clock) disable iff (!rst_n)
		!any_access |=> !reg_rsp.valid;
	endproperty
	a_answer_once: assert property (p_answer_once)
		else $error("register answer without request");

	property p_idle_quiet;
		@(posedge clock) disable iff (!rst_n)
		!reg_rsp.valid |-> !reg_rsp.hit && !reg_rsp.rdata;
	endproperty
	a_idle_quiet: assert property (p_idle_quiet)
		else $error("idle register answer not cleared");

	property p_known_hit;
		@(posedge clock) disable iff (!rst_n)
		known_access |=> reg_rsp.hit;
	endproperty
	a_known_hit: assert property (p_known_hit)
		else $error("mapped offset answered as miss");

	property p_unknown_miss;
		@(posedge clock) disable iff (!rst_n)
		unknown_access |=> !reg_rsp.hit && !reg_rsp.rdata;
	endproperty
	a_unknown_miss: assert property (p_unknown_miss)
		else $error("unmapped offset answered as hit");

	property p_write_no_data;
		@(posedge clock) disable iff (!rst_n)
		reg_req.wr && !reg_req.rd |=> !reg_rsp.rdata;
	endproperty
	a_write_no_data: assert property (p_write_no_data)
		else $error("write answered with read data");

	property p_output_read;
		@(posedge clock) disable iff (!rst_n)
		reg_req.rd && is_access_to(reg_req, LRO_OFF_OUTPUT) |=> reg_rsp.rdata == $past(relay_point_output);
	endproperty
	a_output_read: assert property (p_output_read)
		else $error("relay readback wrong");

	property p_read_old_flag;
		@(posedge clock) disable iff (!rst_n)
		reg_req.rd && flag_write |=> reg_rsp.rdata == $past(flag);
	endproperty
	a_read_old_flag: assert property (p_read_old_flag)
		else $error("read with write did not return old flag");

	// Register contents change only by remote write or by reset
	property p_flag_hold;
		@(posedge clock) disable iff (!rst_n)
		!flag_write |=> $stable(flag);
	endproperty
	a_flag_hold: assert property (p_flag_hold)
		else $error("flag changed without write");

	property p_value_hold;
		@(posedge clock) disable iff (!rst_n)
		!value_write |=> $stable(forced);
	endproperty
	a_value_hold: assert property (p_value_hold)
		else $error("forced value changed without write");

	property p_refused_write;
		@(posedge clock) disable iff (!rst_n)
		reg_req.wr && !flag_write && !value_write |=> $stable(flag) && $stable(forced);
	endproperty
	a_refused_write: assert property (p_refused_write)
		else $error("refused write changed a register");

	// Relay drive and status
	property p_locked_output;
		@(posedge clock) disable iff (!rst_n)
		$past(rst_n) && lock_active |-> relay_point_output == $past(forced);
	endproperty
	a_locked_output: assert property (p_locked_output)
		else $error("locked output differs from forced value");

	property p_unlocked_output;
		@(posedge clock) disable iff (!rst_n)
		$past(rst_n) && !lock_active |-> relay_point_output == $past(source_input);
	endproperty
	a_unlocked_output: assert property (p_unlocked_output)
		else $error("unlocked output differs from source");

	property p_unlock_latency;
		@(posedge clock) disable iff (!rst_n)
		flag_write && !reg_req.wdata |=> ##1 relay_point_output == $past(source_input);
	endproperty
	a_unlock_latency: assert property (p_unlock_latency)
		else $error("unlock write not applied by next evaluation");

	property p_status_steady;
		@(posedge clock) disable iff (!rst_n)
		$stable(flag) |=> $stable(lock_active);
	endproperty
	a_status_steady: assert property (p_status_steady)
		else $error("lock status moved with steady flag");

	property p_forced_steady;
		@(posedge clock) disable iff (!rst_n)
		lock_active && flag && $stable(forced) |=> $stable(relay_point_output);
	endproperty
	a_forced_steady: assert property (p_forced_steady)
		else $error("locked output moved with steady forced value");

	property p_release_quiet;
		@(posedge clock) disable iff (!rst_n)
		$rose(rst_n) |-> !relay_point_output && !lock_active && !reg_rsp.valid;
	endproperty
	a_release_quiet: assert property (p_release_quiet)
		else $error("outputs not at reset values on release");

	a_forced_drive: assert property (@(posedge clock) disable iff (!rst_n)
		flag |=> relay_point_output == $past(forced))
		else $error("output not forced while locked");
	a_pass_through: assert property (@(posedge clock) disable iff (!rst_n)
		!flag |=> relay_point_output == $past(source_input))
		else $error("output not following source while unlocked");
	a_flag_status: assert property (@(posedge clock) disable iff (!rst_n)
		##1 lock_active == $past(flag))
		else $error("lock status does not mirror flag");
	a_write_latency: assert property (@(posedge clock) disable iff (!rst_n)
		reg_req.wr && reg_req.addr == LRO_OFF_ENABLE && reg_req.wdata
		|=> ##1 relay_point_output == $past(forced))
		else $error("lock write not applied by next evaluation");
	a_value_latency: assert property (@(posedge clock) disable iff (!rst_n)
		flag && reg_req.wr && reg_req.addr == LRO_OFF_VALUE && $stable(flag)
		##1 flag |=> relay_point_output == $past(reg_req.wdata, 2))
		else $error("forced value write not applied");
	a_flag_read: assert property (@(posedge clock) disable iff (!rst_n)
		reg_req.rd && reg_req.addr == LRO_OFF_ENABLE |=> reg_rsp.rdata == $past(flag))
		else $error("flag readback wrong");
	a_value_read: assert property (@(posedge clock) disable iff (!rst_n)
		reg_req.rd && reg_req.addr == LRO_OFF_VALUE |=> reg_rsp.valid && reg_rsp.rdata == $past(forced))
		else $error("value readback wrong");
	a_reset_quiet: assert property (@(posedge clock)
		!rst_n |=> !relay_point_output && !lock_active)
		else $error("outputs not cleared by reset");

	c_locked_high: cover property (@(posedge clock) disable iff (!rst_n) lock_active && relay_point_output);
	c_locked_low: cover property (@(posedge clock) disable iff (!rst_n) lock_active && !relay_point_output);
	c_unlock: cover property (@(posedge clock) disable iff (!rst_n) lock_active ##1 !lock_active);
	c_pass: cover property (@(posedge clock) disable iff (!rst_n) !lock_active && relay_point_output);
endmodule

// ==== sim/lro_modbus_master.sv ====
// Remote register master model: one-cycle read or write strobes on the register port.
// Assumes the block registers its answer on the same edge that takes the request.
`timescale 1ns/1ps
module lro_modbus_master (
	input wire logic clock,
	output lro_pkg::lro_req_s req,
	input wire lro_pkg::lro_rsp_s rsp
);
	import lro_pkg::*;
	initial req = '0;
	task automatic access(input logic wr, input logic [LRO_ADDR_W-1:0] addr, input logic wdata, output lro_rsp_s r);
		@(posedge clock) #1 req <= '{wr: wr, rd: !wr, addr: addr, wdata: wdata};
		@(posedge clock) #1 req <= '0;
		r = rsp;
	endtask
endmodule

// ==== sim/lro_override_relay_block_tb.sv ====
// Bench for the relay output override: register traffic through the master model.
// Assumes a 4 ns clock and a synchronous active-low reset.
`timescale 1ns/1ps
module lro_override_relay_block_tb;
	import lro_pkg::*;
	logic clock, rst_n, source_input, relay_point_output, lock_active;
	lro_req_s reg_req;
	lro_rsp_s reg_rsp, r;
	int fails = 0;
	int checks = 0;
	lro_override_relay_block u_lro_override_relay_block(.clock(clock), .rst_n(rst_n), .source_input(source_input),
		.reg_req(reg_req), .reg_rsp(reg_rsp), .relay_point_output(relay_point_output), .lock_active(lock_active));
	lro_modbus_master u_lro_modbus_master(.clock(clock), .req(reg_req), .rsp(reg_rsp));
	initial begin
		clock = 0;
		forever #2 clock = ~clock;
	end
	task automatic cmp(string what, logic exp, logic got);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("unexpected %s expected %b seen %b", what, exp, got);
		end
	endtask
	task automatic step();
		@(posedge clock) #1;
	endtask
	task automatic rd(logic [LRO_ADDR_W-1:0] a, logic hit, logic exp);
		u_lro_modbus_master.access(1'h0, a, 1'h0, r);
		cmp("valid", 1'h1, r.valid);
		cmp("hit", hit, r.hit);
		cmp("rdata", exp, r.rdata);
	endtask
	task automatic wr(logic [LRO_ADDR_W-1:0] a, logic d, logic hit);
		u_lro_modbus_master.access(1'h1, a, d, r);
		cmp("wr valid", 1'h1, r.valid);
		cmp("wr hit", hit, r.hit);
		cmp("wr rdata", 1'h0, r.rdata);
	endtask
	task automatic t_reset();
		cmp("relay", LRO_RST_OUTPUT, relay_point_output);
		cmp("lock", LRO_RST_ENABLE, lock_active);
		rd(LRO_OFF_ENABLE, 1'h1, LRO_RST_ENABLE);
		rd(LRO_OFF_VALUE, 1'h1, LRO_RST_VALUE);
		rd(LRO_OFF_OUTPUT, 1'h1, LRO_RST_OUTPUT);
		$display("test reset done");
	endtask
	task automatic t_pass();
		for (int v = 0; v < 2; v++) begin
			source_input = v[0];
			step();
			step();
			cmp("relay", v[0], relay_point_output);
		end
		$display("test pass done");
	endtask
	task automatic t_lock();
		for (int v = 0; v < 2; v++) begin
			source_input = !v[0];
			wr(LRO_OFF_VALUE, v[0], 1'h1);
			wr(LRO_OFF_ENABLE, 1'h1, 1'h1);
			step();
			cmp("relay", v[0], relay_point_output);
			cmp("lock", 1'h1, lock_active);
			rd(LRO_OFF_ENABLE, 1'h1, 1'h1);
			rd(LRO_OFF_VALUE, 1'h1, v[0]);
			rd(LRO_OFF_OUTPUT, 1'h1, v[0]);
		end
		$display("test lock done");
	endtask
	task automatic t_unlock();
		wr(LRO_OFF_ENABLE, 1'h0, 1'h1);
		step();
		cmp("relay", 1'h0, relay_point_output);
		cmp("lock", 1'h0, lock_active);
		wr(16'h0003, 1'h1, 1'h0);
		rd(16'h0003, 1'h0, 1'h0);
		wr(LRO_OFF_OUTPUT, 1'h1, 1'h1);
		cmp("relay", 1'h0, relay_point_output);
		rd(LRO_OFF_OUTPUT, 1'h1, 1'h0);
		rd(LRO_OFF_ENABLE, 1'h1, 1'h0);
		rd(LRO_OFF_VALUE, 1'h1, 1'h1);
		$display("test unlock done");
	endtask
	task automatic t_reset_mid();
		wr(LRO_OFF_ENABLE, 1'h1, 1'h1);
		step();
		cmp("relay", 1'h1, relay_point_output);
		rst_n = 0;
		step();
		step();
		rst_n = 1;
		cmp("relay", LRO_RST_OUTPUT, relay_point_output);
		cmp("lock", LRO_RST_ENABLE, lock_active);
		rd(LRO_OFF_ENABLE, 1'h1, LRO_RST_ENABLE);
		rd(LRO_OFF_VALUE, 1'h1, LRO_RST_VALUE);
		$display("test reset mid done");
	endtask
	task automatic end_sim();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		#100000;
		fails++;
		end_sim();
	end
	initial begin
		rst_n = 0;
		source_input = 0;
		repeat (12) step();
		rst_n = 1;
		t_reset();
		t_pass();
		t_lock();
		t_unlock();
		t_reset_mid();
		end_sim();
	end
endmodule
